// >>> dv/sdr_bus_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module sdr_bus_ctrl
	import sdr_pkg::*;
(
	// clock
	input  wire logic ref_clk,
	// bytes toward the device
	output sdr_bus_t  bus_out
);
	// idle bus with remote enable true
	initial bus_out = '{valid: 1'b0, atn: 1'b0, ren: 1'b1, data: 8'h00};

	// one byte held for one edge, then released with inverted data
	task automatic put_byte(input logic atn, input logic [7:0] b);
		@(posedge ref_clk);
		#1;
		bus_out.valid = 1'b1;
		bus_out.atn = atn;
		bus_out.data = b;
		@(posedge ref_clk);
		#1;
		bus_out.valid = 1'b0;
		bus_out.data = ~b;
	endtask : put_byte

	// remote message: own listen address while enable is true
	task automatic send_addr(input logic [4:0] a);
		put_byte(1'b1, {MLA_GROUP, a});
	endtask : send_addr

	// ascii data message, one byte per character
	task automatic send_text(input string s);
		foreach (s[i]) put_byte(1'b0, s[i]);
	endtask : send_text

	// remote enable level, low clears lockout and sets local
	task automatic set_ren(input logic v);
		@(posedge ref_clk);
		#1;
		bus_out.ren = v;
		@(posedge ref_clk);
		#1;
	endtask : set_ren
endmodule : sdr_bus_ctrl
`default_nettype wire

// >>> dv/tb_switch_driver_remote_control.sv
`timescale 1ns/10ps
`default_nettype none
module tb_switch_driver_remote_control
	import sdr_pkg::*;
;
	// stimulus and observed outputs
	logic              ref_clk = 1'b0;
	logic              rst_n = 1'b0;
	logic [CHAN_N-1:0] chan_button = '0;
	logic              local_button = 1'b0;
	logic [ADDR_W-1:0] addr_switch = ADDR_DEFAULT;
	sdr_bus_t          bus;
	logic [CHAN_N-1:0] chan_lamp;
	logic              local_lamp;
	logic              remote_lamp;
	logic [3:0]        first_attenuator_port;
	logic [3:0]        second_attenuator_port;
	logic              coax_switch_nine_output;
	logic              coax_switch_zero_output;
	int                fails = 0;
	int                num_checks = 0;
	// button vector and channel state expected after it
	typedef struct packed {logic [9:0] btn; logic [9:0] exp;} sdr_row_t;
	sdr_row_t rows [5] = '{'{10'h001, 10'h3fe}, '{10'h200, 10'h1fe}, '{10'h001, 10'h1ff},
		'{10'h0c0, 10'h13f}, '{10'h3ff, 10'h2c0}};

	// 8 ns clock
	always #4 ref_clk = ~ref_clk;

	sdr_ctrl i_dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .chan_button(chan_button),
		.local_button(local_button), .addr_switch(addr_switch), .bus_in(bus),
		.chan_lamp(chan_lamp), .local_lamp(local_lamp), .remote_lamp(remote_lamp),
		.first_attenuator_port(first_attenuator_port),
		.second_attenuator_port(second_attenuator_port),
		.coax_switch_nine_output(coax_switch_nine_output),
		.coax_switch_zero_output(coax_switch_zero_output)
	);

	sdr_bus_ctrl i_bus (
		.ref_clk(ref_clk),
		.bus_out(bus)
	);

	// compare and count
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	// lamps and drive outputs against one expected state
	task automatic check_all(input logic [9:0] ec, input logic el, input logic er);
		check({6'h00, chan_lamp}, {6'h00, ec});
		check({6'h00, coax_switch_zero_output, coax_switch_nine_output, second_attenuator_port,
			first_attenuator_port}, {6'h00, ec});
		check({14'h0000, local_lamp, remote_lamp}, {14'h0000, el, er});
	endtask : check_all

	// wait n edges, then step off the edge
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick

	// press and release {local key, numbered buttons}, wait for sync
	task automatic press(input logic [10:0] v);
		tick(1);
		{local_button, chan_button} = v;
		tick(1);
		{local_button, chan_button} = 11'h000;
		tick(3);
	endtask : press

	task automatic do_reset;
		tick(1);
		rst_n = 1'b0;
		tick(10);
		rst_n = 1'b1;
		tick(1);
	endtask : do_reset

	task automatic print_verdict;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict

	// watchdog, run needs about 175 cycles
	initial begin
		repeat (3000) @(posedge ref_clk);
		fails++;
		print_verdict();
	end

	initial begin
		do_reset();
		check_all(CHAN_RESET, 1'b1, 1'b0);
		foreach (rows[i]) begin
			press({1'b0, rows[i].btn});
			check_all(rows[i].exp, 1'b1, 1'b0);
		end
		$display("test local buttons done");
		do_reset();
		i_bus.send_addr(addr_switch);
		check_all(CHAN_RESET, 1'b0, 1'b1);
		press(11'h001);
		check_all(CHAN_RESET, 1'b0, 1'b1);
		i_bus.send_text("B1234567890");
		check_all(10'h000, 1'b0, 1'b1);
		i_bus.send_text("A1234567890");
		check_all(10'h3ff, 1'b0, 1'b1);
		i_bus.send_text("b1Z3");
		check_all(10'h3fa, 1'b0, 1'b1);
		i_bus.put_byte(1'b1, CMD_LLO);
		press(11'h400);
		check_all(10'h3fa, 1'b0, 1'b1);
		i_bus.set_ren(1'b0);
		check_all(10'h3fa, 1'b1, 1'b0);
		i_bus.set_ren(1'b1);
		press(11'h100);
		check_all(10'h2fa, 1'b1, 1'b0);
		$display("test remote and lockout done");
		addr_switch = 5'h05;
		tick(4);
		i_bus.send_addr(ADDR_DEFAULT);
		check_all(10'h2fa, 1'b1, 1'b0);
		i_bus.send_addr(5'h05);
		check_all(10'h2fa, 1'b0, 1'b1);
		press(11'h400);
		check_all(10'h2fa, 1'b1, 1'b0);
		i_bus.send_text("a9");
		check_all(10'h2fa, 1'b1, 1'b0);
		i_bus.send_addr(5'h05);
		i_bus.send_text("0a1");
		check_all(10'h2fb, 1'b0, 1'b1);
		i_bus.put_byte(1'b1, CMD_GTL);
		check_all(10'h2fb, 1'b1, 1'b0);
		i_bus.send_addr(5'h05);
		i_bus.put_byte(1'b1, CMD_UNL);
		i_bus.send_text("b1");
		check_all(10'h2fb, 1'b0, 1'b1);
		i_bus.send_addr(5'h05);
		do_reset();
		check_all(CHAN_RESET, 1'b1, 1'b0);
		$display("test address and power cycle done");
		print_verdict();
	end
endmodule : tb_switch_driver_remote_control
`default_nettype wire

// >>> rtl/sdr_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module sdr_ctrl
	import sdr_pkg::*;
(
	// clock and reset
	input  wire logic                ref_clk,
	input  wire logic                rst_n,
	// front panel pins, pressed high
	input  wire logic [CHAN_N-1:0]   chan_button,
	input  wire logic                local_button,
	// rear address switches
	input  wire logic [ADDR_W-1:0]   addr_switch,
	// bytes from the bus handshake layer, same clock
	input  wire sdr_bus_t            bus_in,
	// lamps
	output logic [CHAN_N-1:0]        chan_lamp,
	output logic                     local_lamp,
	output logic                     remote_lamp,
	// channel drive outputs
	output logic [3:0]               first_attenuator_port,
	output logic [3:0]               second_attenuator_port,
	output logic                     coax_switch_nine_output,
	output logic                     coax_switch_zero_output
);

	// synchronisers for panel pins
	logic [CHAN_N-1:0]  btn_s1;
	logic [CHAN_N-1:0]  btn_s2;
	logic [CHAN_N-1:0]  btn_prev;
	logic               loc_s1;
	logic               loc_s2;
	logic               loc_prev;
	logic [ADDR_W-1:0]  addr_s1;
	logic [ADDR_W-1:0]  addr_s2;
	logic [ADDR_W-1:0]  listen_addr;

	// control state
	sdr_mode_t          mode;
	sdr_mode_t          next_mode;
	logic               lockout;
	logic               next_lockout;
	logic               listen;
	logic               next_listen;
	sdr_letter_t        letter;
	sdr_letter_t        next_letter;
	logic [CHAN_N-1:0]  chan_state;
	logic [CHAN_N-1:0]  next_chan;
	logic               next_local_lamp;
	logic               next_remote_lamp;

	// decoded events
	logic [CHAN_N-1:0]  btn_press;
	logic               local_press;
	logic [7:0]         mla;
	logic               cmd_valid;
	logic               data_apply;
	logic [7:0]         low_case;
	logic               is_on_letter;
	logic               is_off_letter;
	logic [CHAN_N-1:0]  dig_hit;

	// pin synchronisers and address capture
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			btn_s1      <= '0;
			btn_s2      <= '0;
			btn_prev    <= '0;
			loc_s1      <= 1'b0;
			loc_s2      <= 1'b0;
			loc_prev    <= 1'b0;
			addr_s1     <= ADDR_DEFAULT;
			addr_s2     <= ADDR_DEFAULT;
			listen_addr <= ADDR_DEFAULT;
		end else begin
			btn_s1      <= chan_button;
			btn_s2      <= btn_s1;
			btn_prev    <= btn_s2;
			loc_s1      <= local_button;
			loc_s2      <= loc_s1;
			loc_prev    <= loc_s2;
			addr_s1     <= addr_switch;
			addr_s2     <= addr_s1;
			listen_addr <= addr_s2;
		end
	end

	// press edges and byte classification
	assign btn_press     = btn_s2 & ~btn_prev;
	assign local_press   = loc_s2 & ~loc_prev;
	assign mla           = {MLA_GROUP, listen_addr};
	assign cmd_valid     = bus_in.valid & bus_in.atn;
	assign data_apply    = bus_in.valid & ~bus_in.atn & listen & (mode == SDR_REMOTE);
	assign low_case      = bus_in.data | ASCII_CASE;
	assign is_on_letter  = (low_case == ASCII_LOWER_A);
	assign is_off_letter = (low_case == ASCII_LOWER_B);

	// digit decode: bit i is button i+1, the last bit is button zero
	genvar g;
	generate
		for (g = 0; g < CHAN_N; g++) begin : g_digit
			localparam logic [7:0] CODE = (g == CHAN_N - 1) ? ASCII_ZERO : 8'(ASCII_ONE + g);
			assign dig_hit[g] = (bus_in.data == CODE);
		end
	endgenerate

	// next control state
	always_comb begin
		next_mode    = mode;
		next_lockout = lockout;
		next_listen  = listen;
		next_letter  = letter;
		next_chan    = chan_state;
		// buttons act only in local mode
		if (mode == SDR_LOCAL) begin
			next_chan = chan_state ^ btn_press;
		end
		// data message characters
		if (data_apply) begin
			if (is_on_letter) begin
				next_letter = SDR_LT_ON;
			end else if (is_off_letter) begin
				next_letter = SDR_LT_OFF;
			end else if (letter == SDR_LT_ON) begin
				next_chan = chan_state | dig_hit;
			end else if (letter == SDR_LT_OFF) begin
				next_chan = chan_state & ~dig_hit;
			end
		end
		// interface commands
		if (cmd_valid) begin
			if (bus_in.data == mla) begin
				next_listen = 1'b1;
				next_letter = SDR_LT_NONE;
				if (bus_in.ren) begin
					next_mode = SDR_REMOTE;
				end
			end else if (bus_in.data == CMD_UNL) begin
				next_listen = 1'b0;
			end else if (bus_in.data == CMD_LLO) begin
				next_lockout = 1'b1;
			end else if ((bus_in.data == CMD_GTL) && listen) begin
				next_mode = SDR_LOCAL;
			end
		end
		// local key returns to local unless locked out
		if ((mode == SDR_REMOTE) && !lockout && local_press) begin
			next_mode = SDR_LOCAL;
		end
		// remote enable false clears lockout and sets local
		if (!bus_in.ren) begin
			next_mode    = SDR_LOCAL;
			next_lockout = 1'b0;
		end
		next_local_lamp  = (next_mode == SDR_LOCAL);
		next_remote_lamp = (next_mode == SDR_REMOTE);
	end

	// control registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode        <= SDR_LOCAL;
			lockout     <= 1'b0;
			listen      <= 1'b0;
			letter      <= SDR_LT_NONE;
			chan_state  <= CHAN_RESET;
			local_lamp  <= 1'b1;
			remote_lamp <= 1'b0;
		end else begin
			mode        <= next_mode;
			lockout     <= next_lockout;
			listen      <= next_listen;
			letter      <= next_letter;
			chan_state  <= next_chan;
			local_lamp  <= next_local_lamp;
			remote_lamp <= next_remote_lamp;
		end
	end

	// lamps and outputs share the one stored bit per channel
	assign chan_lamp               = chan_state;
	assign first_attenuator_port   = chan_state[3:0];
	assign second_attenuator_port  = chan_state[7:4];
	assign coax_switch_nine_output = chan_state[8];
	assign coax_switch_zero_output = chan_state[9];

	// checking helpers
	logic post_rst;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			post_rst <= 1'b0;
		end else begin
			post_rst <= 1'b1;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	// first cycle after reset shows every channel on and local
	a_reset_all_on: assert property (!post_rst |-> (chan_state == CHAN_RESET) && local_lamp && !remote_lamp)
		else $error("reset state wrong");

	// a local press toggles exactly the pressed channels
	a_press_toggles: assert property ((mode == SDR_LOCAL) |=> chan_state == $past(chan_state ^ btn_press))
		else $error("local press did not toggle only its channel");

	// remote mode ignores numbered buttons
	a_remote_ignores_btn: assert property ((mode == SDR_REMOTE) && !data_apply |=> $stable(chan_state))
		else $error("channel changed in remote without data");

	// own listen address with remote enable enters remote, channels kept
	a_mla_to_remote: assert property (cmd_valid && bus_in.ren && (bus_in.data == mla) && (mode == SDR_LOCAL)
		&& (btn_press == '0) |=> remote_lamp && !local_lamp && $stable(chan_state))
		else $error("remote message not taken");

	// on letter then digit sets the channel
	a_data_sets_on: assert property (data_apply && (letter == SDR_LT_ON) && !is_on_letter && !is_off_letter
		|=> (chan_state & $past(dig_hit)) == $past(dig_hit))
		else $error("on code did not set channel");

	// off letter then digit clears the channel, others untouched
	a_data_sets_off: assert property (data_apply && (letter == SDR_LT_OFF) && !is_on_letter && !is_off_letter
		|=> chan_state == ($past(chan_state) & ~$past(dig_hit)))
		else $error("off code wrong");

	// lockout keeps remote over a local key press
	a_lockout_holds: assert property ((mode == SDR_REMOTE) && lockout && bus_in.ren && local_press && !cmd_valid
		|=> remote_lamp && !local_lamp)
		else $error("local key escaped lockout");

	// remote enable false returns to local and clears lockout
	a_ren_to_local: assert property (!bus_in.ren |=> local_lamp && !remote_lamp && !lockout)
		else $error("clear lockout/set local not honoured");

	// nothing but a press or a data byte moves a channel
	a_mode_keeps_chan: assert property ((btn_press == '0) && !data_apply |=> $stable(chan_state))
		else $error("channel changed without cause");

	// lamps and outputs agree
	a_lamp_out_agree: assert property (chan_lamp == {coax_switch_zero_output, coax_switch_nine_output,
		second_attenuator_port, first_attenuator_port})
		else $error("lamp and output disagree");

	// lockout command sets the lockout flag
	a_llo_sets_lock: assert property (cmd_valid && bus_in.ren && (bus_in.data == CMD_LLO) |=> lockout)
		else $error("lockout command not taken");

	// local key without lockout leaves remote
	a_local_key_exit: assert property ((mode == SDR_REMOTE) && !lockout && local_press
		|=> local_lamp && !remote_lamp)
		else $error("local key did not return to local");

	// unlisten stops the device listening
	a_unl_clears: assert property (cmd_valid && (bus_in.data == CMD_UNL) && (bus_in.data != mla)
		|=> !listen)
		else $error("unlisten not taken");

	// go-to-local while listening returns to local, channels kept
	a_gtl_to_local: assert property (cmd_valid && listen && (bus_in.data == CMD_GTL) && (btn_press == '0)
		|=> local_lamp && !remote_lamp && $stable(chan_state))
		else $error("go-to-local not taken");

	// own listen address starts a fresh data message
	a_mla_new_msg: assert property (cmd_valid && (bus_in.data == mla)
		|=> listen && (letter == SDR_LT_NONE))
		else $error("listen address did not reset the message");

	// data bytes in local mode leave the channels alone
	a_local_no_data: assert property (bus_in.valid && !bus_in.atn && (mode == SDR_LOCAL) && (btn_press == '0)
		|=> $stable(chan_state))
		else $error("data applied in local mode");

	// digits before any letter are ignored
	a_digit_no_letter: assert property (data_apply && (letter == SDR_LT_NONE) |=> $stable(chan_state))
		else $error("digit applied without a letter");

	// main scenarios
	c_local_press: cover property ((mode == SDR_LOCAL) && (btn_press != '0));
	c_data_off_all: cover property (data_apply ##1 (chan_state == '0));
	c_lockout_press: cover property ((mode == SDR_REMOTE) && lockout && local_press);
	c_back_to_local: cover property ((mode == SDR_REMOTE) ##1 (mode == SDR_LOCAL) ##[1:20] (btn_press != '0));
	c_unlisten: cover property (cmd_valid && (bus_in.data == CMD_UNL) ##1 !listen);

endmodule : sdr_ctrl
`default_nettype wire

// >>> shared/sdr_pkg.sv
`default_nettype none
package sdr_pkg;
	// channel count and listen address width
	localparam int          CHAN_N        = 10;
	localparam int          ADDR_W        = 5;
	// all channels on after power-up
	localparam logic [9:0]  CHAN_RESET    = 10'h3ff;
	// factory address 28
	localparam logic [4:0]  ADDR_DEFAULT  = 5'h1c;
	// listen address group is 001xxxxx
	localparam logic [2:0]  MLA_GROUP     = 3'h1;
	// interface commands sent with attention true
	localparam logic [7:0]  CMD_GTL       = 8'h01;
	localparam logic [7:0]  CMD_LLO       = 8'h11;
	localparam logic [7:0]  CMD_UNL       = 8'h3f;
	// ascii codes of the data message
	localparam logic [7:0]  ASCII_ZERO    = 8'h30;
	localparam logic [7:0]  ASCII_ONE     = 8'h31;
	localparam logic [7:0]  ASCII_LOWER_A = 8'h61;
	localparam logic [7:0]  ASCII_LOWER_B = 8'h62;
	localparam logic [7:0]  ASCII_CASE    = 8'h20;

	// front-panel control mode
	typedef enum logic [0:0] {
		SDR_LOCAL  = 1'b0,
		SDR_REMOTE = 1'b1
	} sdr_mode_t;

	// command letter seen last in the data message
	typedef enum logic [1:0] {
		SDR_LT_NONE = 2'b00,
		SDR_LT_ON   = 2'b01,
		SDR_LT_OFF  = 2'b10
	} sdr_letter_t;

	// one byte from the bus handshake layer plus the remote enable line
	typedef struct packed {
		logic       valid;
		logic       atn;
		logic       ren;
		logic [7:0] data;
	} sdr_bus_t;
endpackage : sdr_pkg
`default_nettype wire
